/* File: src/dmcp_pkg.sv */
// package: shared constants for the dual mode control port
package dmcp_pkg;
	localparam logic [5:0] I2C_ADDR_FIXED = 6'h08; // upper six address bits 001000
	localparam logic [7:0] SPI_ADDR_BYTE = 8'h20; // fixed spi address byte 00100000
	localparam int PTR_AUTOINC_BIT = 7; // auto-increment enable position
	localparam int PTR_IDX_W = 3; // register select width
	localparam logic [7:0] PTR_RESET = 8'h00; // pointer default
	localparam int NUM_REGS = 5; // configuration registers present
	localparam int LINK_DIV = 4; // host link clock half period in clk cycles
endpackage

/* File: src/dmcp_link_if.sv */
// interface: pins between host controller and control port
`timescale 1ns/1ps
interface dmcp_link_if;
	logic ctrl_clk; // shared_ctrl_clock_pin, host driven
	logic sel_pin; // addr_or_select_shared_pin, host driven
	logic data_in; // serial_ctrl_data_in (spi data), host driven
	logic sda_host_o;
	logic sda_host_oe;
	logic sda_dev_o;
	logic sda_dev_oe;
	logic sda; // resolved open-drain line
	assign sda = ~((sda_host_oe & ~sda_host_o) | (sda_dev_oe & ~sda_dev_o));
	modport dev (input ctrl_clk, input sel_pin, input data_in, input sda, output sda_dev_o, output sda_dev_oe);
	modport host (output ctrl_clk, output sel_pin, output data_in, input sda, output sda_host_o,
		output sda_host_oe);
endinterface

/* File: src/dmcp_device.sv */
// device end: i2c/spi slave holding configuration registers
`timescale 1ns/1ps
module dmcp_device import dmcp_pkg::*; (
	// clock and reset (master clock)
	input wire logic clk,
	input wire logic arst_n,
	// link pins
	dmcp_link_if.dev link,
	// user side: register contents
	output logic [8*NUM_REGS-1:0] regs_out,
	output logic spi_mode
);
	// synchronisers: two flops per pin before any logic
	logic [1:0] scl_s_ff, sda_s_ff, sel_s_ff, din_s_ff;
	logic scl_d_ff, sda_d_ff, sel_d_ff;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_s_ff <= 2'h3;
			sda_s_ff <= 2'h3;
			sel_s_ff <= 2'h0;
			din_s_ff <= 2'h0;
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
			sel_d_ff <= 1'b0;
		end else begin
			scl_s_ff <= {scl_s_ff[0], link.ctrl_clk};
			sda_s_ff <= {sda_s_ff[0], link.sda};
			sel_s_ff <= {sel_s_ff[0], link.sel_pin};
			din_s_ff <= {din_s_ff[0], link.data_in};
			scl_d_ff <= scl_s_ff[1];
			sda_d_ff <= sda_s_ff[1];
			sel_d_ff <= sel_s_ff[1];
		end
	end
	logic scl, sda, sel, din;
	assign scl = scl_s_ff[1];
	assign sda = sda_s_ff[1];
	assign sel = sel_s_ff[1];
	assign din = din_s_ff[1];
	logic scl_rise, scl_fall, start_c, stop_c, sel_fall, sel_rise;
	assign scl_rise = scl & ~scl_d_ff;
	assign scl_fall = ~scl & scl_d_ff;
	assign start_c = scl & scl_d_ff & sda_d_ff & ~sda; // sda falls while scl high
	assign stop_c = scl & scl_d_ff & ~sda_d_ff & sda;
	assign sel_fall = sel_d_ff & ~sel;
	assign sel_rise = ~sel_d_ff & sel;

	// strap capture: address-select level sampled after reset release
	logic strap_ok_ff, strap_ff, spi_ff;
	logic [1:0] strap_cnt_ff; // edges since release; sel only holds the pin once both sync flops have loaded
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_ok_ff <= 1'b0;
			strap_ff <= 1'b0;
			strap_cnt_ff <= 2'h0;
		end else if (!strap_ok_ff) begin
			strap_cnt_ff <= strap_cnt_ff + 2'h1;
			// capturing earlier would read the synchroniser's reset value, not the strap
			if (strap_cnt_ff == 2'h2) begin
				strap_ok_ff <= 1'b1;
				strap_ff <= sel;
			end
		end
	end
	// mode latch: spi is sticky until reset
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			spi_ff <= 1'b0;
		else if (sel_fall && strap_ok_ff)
			spi_ff <= 1'b1;
	end
	assign spi_mode = spi_ff;

	// protocol states
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001, // waiting for start / select
		ST_ADDR = 6'b000010, // receiving address byte
		ST_PTR = 6'b000100, // receiving pointer byte
		ST_WDAT = 6'b001000, // receiving data byte
		ST_RDAT = 6'b010000, // sending data byte
		ST_ACK = 6'b100000 // ack slot
	} dmcp_state_t;
	dmcp_state_t state_ff;
	dmcp_state_t after_ack_ff; // state to enter after ack slot
	logic [7:0] shift_ff; // receive / transmit shifter
	logic [3:0] bit_ff; // bits done in current byte
	logic [7:0] ptr_ff; // register pointer
	logic [7:0] regs_ff [NUM_REGS];
	logic sda_oe_ff; // open-drain enable, updated with the state
	logic rd_ack_ff; // host ack sampled in read
	logic rd_mode_ff; // current ack slot follows a read byte

	// register read mux; missing registers read as zero
	logic [7:0] rd_byte;
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_ff[PTR_IDX_W-1:0] < 3'(NUM_REGS))
			rd_byte = regs_ff[ptr_ff[PTR_IDX_W-1:0]];
	end
	logic [7:0] nxt_ptr_inc;
	// auto-increment only touches the select bits, keeping the enable
	assign nxt_ptr_inc = ptr_ff[PTR_AUTOINC_BIT] ?
		{ptr_ff[7:PTR_IDX_W], ptr_ff[PTR_IDX_W-1:0] + 3'h1} : ptr_ff;

	logic [7:0] byte_in;
	assign byte_in = {shift_ff[6:0], spi_ff ? din : sda};
	logic bit_clk; // serial clock rising sample
	assign bit_clk = scl_rise;

	// main protocol engine; sda drive changes with the state, one cycle after the
	// fall is seen, so it settles one cycle before the host raises the clock again
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_ff <= ST_IDLE;
			after_ack_ff <= ST_IDLE;
			shift_ff <= 8'h00;
			bit_ff <= 4'h0;
			ptr_ff <= PTR_RESET;
			sda_oe_ff <= 1'b0;
			rd_mode_ff <= 1'b0;
			rd_ack_ff <= 1'b0;
			for (int i = 0; i < NUM_REGS; i++)
				regs_ff[i] <= 8'h00;
		end else if (spi_ff) begin
			// spi: framed by select low, sampled on rising clock
			sda_oe_ff <= 1'b0; // every pin an input in spi
			if (sel || sel_rise) begin
				state_ff <= ST_IDLE; // select high ends frame
				bit_ff <= 4'h0;
			end else if (state_ff == ST_IDLE) begin
				state_ff <= ST_ADDR;
				bit_ff <= 4'h0;
			end else if (bit_clk) begin
				shift_ff <= byte_in;
				bit_ff <= bit_ff + 4'h1;
				if (bit_ff == 4'h7) begin
					bit_ff <= 4'h0;
					case (state_ff)
						ST_ADDR: state_ff <= (byte_in == SPI_ADDR_BYTE) ? ST_PTR : ST_ACK;
						ST_PTR: begin
							ptr_ff <= byte_in;
							state_ff <= ST_WDAT;
						end
						ST_WDAT: begin
							if (ptr_ff[PTR_IDX_W-1:0] < 3'(NUM_REGS))
								regs_ff[ptr_ff[PTR_IDX_W-1:0]] <= byte_in;
							ptr_ff <= nxt_ptr_inc;
						end
						default: state_ff <= ST_ACK; // ignore remainder of frame
					endcase
				end
			end
		end else if (start_c) begin
			// start or repeated start restarts from address byte
			state_ff <= ST_ADDR;
			bit_ff <= 4'h0;
			sda_oe_ff <= 1'b0;
		end else if (stop_c) begin
			state_ff <= ST_IDLE;
			sda_oe_ff <= 1'b0;
		end else begin
			case (state_ff)
				ST_ADDR, ST_PTR, ST_WDAT: begin
					if (bit_clk) begin
						shift_ff <= byte_in;
						bit_ff <= bit_ff + 4'h1;
					end
					if (scl_fall && bit_ff == 4'h8) begin
						bit_ff <= 4'h0;
						rd_mode_ff <= 1'b0;
						state_ff <= ST_ACK;
						sda_oe_ff <= 1'b1; // acknowledge
						if (state_ff == ST_ADDR) begin
							if (shift_ff[7:2] != I2C_ADDR_FIXED || shift_ff[1] != strap_ff) begin
								sda_oe_ff <= 1'b0;
								state_ff <= ST_IDLE;
							end else
								after_ack_ff <= shift_ff[0] ? ST_RDAT : ST_PTR;
						end else if (state_ff == ST_PTR) begin
							ptr_ff <= shift_ff;
							after_ack_ff <= ST_WDAT;
						end else begin
							if (ptr_ff[PTR_IDX_W-1:0] < 3'(NUM_REGS))
								regs_ff[ptr_ff[PTR_IDX_W-1:0]] <= shift_ff;
							ptr_ff <= nxt_ptr_inc;
							after_ack_ff <= ST_WDAT;
						end
					end
				end
				ST_ACK: begin
					if (bit_clk)
						rd_ack_ff <= ~sda; // host ack seen in read slot
					if (scl_fall) begin
						sda_oe_ff <= 1'b0;
						if (rd_mode_ff && !rd_ack_ff)
							state_ff <= ST_IDLE; // nack ends read
						else begin
							state_ff <= after_ack_ff;
							if (after_ack_ff == ST_RDAT) begin
								shift_ff <= rd_byte; // load byte at pointer
								sda_oe_ff <= !rd_byte[7]; // first bit out
							end
						end
					end
				end
				ST_RDAT: begin
					if (scl_fall) begin
						bit_ff <= bit_ff + 4'h1;
						shift_ff <= {shift_ff[6:0], 1'b1};
						sda_oe_ff <= !shift_ff[6]; // next bit out
						if (bit_ff == 4'h7) begin
							bit_ff <= 4'h0;
							sda_oe_ff <= 1'b0; // host owns the ack slot
							state_ff <= ST_ACK;
							rd_mode_ff <= 1'b1;
							after_ack_ff <= ST_RDAT;
							ptr_ff <= nxt_ptr_inc;
						end
					end
				end
				default: begin
					state_ff <= ST_IDLE;
					sda_oe_ff <= 1'b0;
				end
			endcase
		end
	end

	// open-drain drive: only ever pulls low
	assign link.sda_dev_o = 1'b0;
	assign link.sda_dev_oe = sda_oe_ff;

	// register image to the converter core
	logic [8*NUM_REGS-1:0] regs_flat_ff;
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			regs_flat_ff <= '0;
		else
			for (int i = 0; i < NUM_REGS; i++)
				regs_flat_ff[8*i +: 8] <= regs_ff[i];
	end
	assign regs_out = regs_flat_ff;
endmodule // dmcp_device

/* File: src/dmcp_host.sv */
// host end: i2c/spi master issuing single-byte transactions
`timescale 1ns/1ps
module dmcp_host import dmcp_pkg::*; (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// link pins
	dmcp_link_if.host link,
	// command port
	input wire logic cmd_valid, // one-cycle request
	input wire logic cmd_spi, // 1: spi write, 0: i2c
	input wire logic cmd_read, // i2c read of one byte
	input wire logic cmd_strap, // address-select level of device
	input wire logic [7:0] cmd_ptr, // pointer byte (writes)
	input wire logic [7:0] cmd_data, // data byte (writes)
	output logic busy,
	output logic done, // one-cycle pulse
	output logic [7:0] rd_data,
	output logic nack
);
	// host-sequenced frames: address, pointer, data (reads: address, data); one register per frame
	typedef enum logic [4:0] {
		H_IDLE = 5'b00001,
		H_START = 5'b00010,
		H_BITS = 5'b00100,
		H_STOP = 5'b01000,
		H_DONE = 5'b10000
	} dmcp_hstate_t;
	dmcp_hstate_t st_ff;
	logic [26:0] tx_ff; // bits to send, msb first (ack slots as 1)
	logic [4:0] cnt_ff; // bits remaining
	logic [2:0] ph_ff; // half-period divider
	logic hph_ff; // clock phase: 0 low, 1 high
	logic spi_ff, read_ff;
	logic scl_ff, sdao_ff, sel_ff, din_ff;
	logic [7:0] rd_ff;
	logic nack_ff, done_ff;
	logic [1:0] sda_s_ff; // synchroniser for returned sda
	logic [4:0] idx_ff; // bit index within frame
	logic tick;
	assign tick = (ph_ff == 3'(LINK_DIV - 1));
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n)
			sda_s_ff <= 2'h3;
		else
			sda_s_ff <= {sda_s_ff[0], link.sda};
	end
	// sequencer: pins stay static when idle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= H_IDLE;
			tx_ff <= '0;
			cnt_ff <= 5'h00;
			idx_ff <= 5'h00;
			ph_ff <= 3'h0;
			hph_ff <= 1'b0;
			spi_ff <= 1'b0;
			read_ff <= 1'b0;
			scl_ff <= 1'b1;
			sdao_ff <= 1'b1;
			sel_ff <= 1'b1;
			din_ff <= 1'b0;
			rd_ff <= 8'h00;
			nack_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			ph_ff <= tick ? 3'h0 : ph_ff + 3'h1;
			case (st_ff)
				H_IDLE: begin
					ph_ff <= 3'h0;
					if (cmd_valid) begin
						spi_ff <= cmd_spi;
						read_ff <= cmd_read & ~cmd_spi; // spi is write-only
						nack_ff <= 1'b0;
						idx_ff <= 5'h00;
						if (cmd_spi)
							tx_ff <= {SPI_ADDR_BYTE, cmd_ptr, cmd_data, 3'h7};
						else if (cmd_read)
							tx_ff <= {I2C_ADDR_FIXED, cmd_strap, 1'b1, 1'b1, 8'hff, 1'b1, 9'h1ff};
						else
							tx_ff <= {I2C_ADDR_FIXED, cmd_strap, 1'b0, 1'b1, cmd_ptr, 1'b1, cmd_data, 1'b1};
						cnt_ff <= cmd_spi ? 5'd24 : (cmd_read ? 5'd18 : 5'd27);
						st_ff <= H_START;
					end
				end
				H_START: begin
					// i2c start: sda low with clock high; spi: select low
					// clock stays high while select falls; it drops at the end of this phase
					if (spi_ff)
						sel_ff <= 1'b0;
					else
						sdao_ff <= 1'b0;
					hph_ff <= 1'b0;
					if (tick) begin
						scl_ff <= 1'b0;
						st_ff <= H_BITS;
					end
				end
				H_BITS: begin
					if (tick) begin
						hph_ff <= ~hph_ff;
						if (!hph_ff) begin
							// low phase end: raise clock; the bit was presented earlier in the low phase
							scl_ff <= 1'b1;
						end else begin
							scl_ff <= 1'b0;
							if (!spi_ff && idx_ff == 5'd8 && sda_s_ff[1])
								nack_ff <= 1'b1; // device did not ack address
							if (read_ff && idx_ff >= 5'd9 && idx_ff <= 5'd16)
								rd_ff <= {rd_ff[6:0], sda_s_ff[1]};
							tx_ff <= {tx_ff[25:0], 1'b1};
							idx_ff <= idx_ff + 5'h01;
							cnt_ff <= cnt_ff - 5'h01;
							if (cnt_ff == 5'h01)
								st_ff <= H_STOP;
						end
					end
					if (spi_ff)
						din_ff <= tx_ff[26];
					// data moves mid low phase, when the device has released its bit
					else if (!hph_ff && ph_ff == 3'(LINK_DIV / 2))
						sdao_ff <= (read_ff && idx_ff == 5'd17) ? 1'b1 : tx_ff[26]; // nack last byte
				end
				H_STOP: begin
					// stop: sda rises with clock high; spi: select high
					if (!hph_ff && ph_ff == 3'(LINK_DIV / 2))
						sdao_ff <= 1'b0; // after the device lets go of its last ack
					if (tick) begin
						scl_ff <= 1'b1;
						hph_ff <= ~hph_ff;
						if (hph_ff) begin
							sdao_ff <= 1'b1;
							sel_ff <= 1'b1;
							st_ff <= H_DONE;
						end
					end
				end
				H_DONE: begin
					done_ff <= 1'b1;
					st_ff <= H_IDLE;
				end
				default: st_ff <= H_IDLE;
			endcase
		end
	end
	assign link.ctrl_clk = scl_ff;
	assign link.sel_pin = sel_ff;
	assign link.data_in = din_ff;
	assign link.sda_host_o = 1'b0;
	assign link.sda_host_oe = ~sdao_ff;
	assign busy = (st_ff != H_IDLE);
	assign done = done_ff;
	assign rd_data = rd_ff;
	assign nack = nack_ff;
endmodule // dmcp_host

/* File: sim/dmcp_link_asserts.sv */
// checker: protocol assertions on the control port link
`timescale 1ns/1ps
module dmcp_link_asserts (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// host driven pins
	input wire logic ctrl_clk,
	input wire logic sel_pin,
	input wire logic data_in,
	// open-drain data line and its drivers
	input wire logic sda,
	input wire logic sda_host_o,
	input wire logic sda_host_oe,
	input wire logic sda_dev_o,
	input wire logic sda_dev_oe
);
	logic spi_seen_ff; // select pin has fallen since reset
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	// sticky spi detect, set two cycles before the mode latch
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			spi_seen_ff <= 1'b0;
		end else if ($fell(sel_pin)) begin
			spi_seen_ff <= 1'b1;
		end
	end
	AST_OPEN_DRAIN: assert property (sda_dev_oe |-> !sda_dev_o && !sda)
		else $error("device drive does not pull sda low");
	AST_SPI_ALL_INPUTS: assert property (spi_seen_ff |-> !sda_dev_oe)
		else $error("device drives sda in spi mode");
	AST_DEV_CHANGES_CLK_LOW: assert property ($rose(sda_dev_oe) |-> !ctrl_clk)
		else $error("device pulls sda while serial clock high");
	AST_DEV_BIT_HOLD: assert property ($rose(sda_dev_oe) |-> sda_dev_oe [*4])
		else $error("device bit shorter than a clock phase");
	AST_DEV_RELEASE: assert property (sda_dev_oe |-> ##[1:100] !sda_dev_oe)
		else $error("device holds sda too long");
	AST_NO_CONTENTION: assert property (sda_dev_oe |-> !sda_host_oe)
		else $error("both ends drive sda");
	AST_CLK_LOW_PHASE: assert property ($fell(ctrl_clk) |-> !ctrl_clk [*4])
		else $error("serial clock low phase too short");
	AST_CLK_HIGH_PHASE: assert property ($rose(ctrl_clk) |-> ctrl_clk [*4])
		else $error("serial clock high phase too short");
	AST_SEL_FALL_CLK_HIGH: assert property ($fell(sel_pin) |-> ctrl_clk)
		else $error("select falls with serial clock low");
	AST_SPI_IDLE_CLK: assert property (spi_seen_ff && sel_pin |-> ctrl_clk)
		else $error("serial clock moves while deselected");
	// main scenarios reached
	cover property ($rose(sda_dev_oe) && !spi_seen_ff);
	cover property ($fell(sel_pin));
	cover property ($rose(spi_seen_ff));
endmodule // dmcp_link_asserts

/* File: sim/test_dual_mode_control_port.sv */
// testbench: host and device ends joined, checked against a pointer model
`timescale 1ns/1ps
module test_dual_mode_control_port import dmcp_pkg::*; ();
	logic clk = 1'b0; // 10 MHz master clock
	logic arst_n = 1'b0;
	logic cmd_valid = 1'b0, cmd_spi = 1'b0, cmd_read = 1'b0, cmd_strap = 1'b1;
	logic [7:0] cmd_ptr = 8'h00, cmd_data = 8'h00;
	logic busy, done, nack, spi_mode;
	logic [7:0] rd_data;
	logic [8*NUM_REGS-1:0] regs_out;
	int failures = 0, n_checks = 0;
	int mdl[NUM_REGS]; // model register contents
	int mptr = 0; // model pointer
	integer seed = 32'hedae1358;
	dmcp_link_if link_if ();
	dmcp_device dmcp_device_inst (.clk(clk), .arst_n(arst_n), .link(link_if.dev), .regs_out(regs_out),
		.spi_mode(spi_mode));
	dmcp_host dmcp_host_inst (.clk(clk), .arst_n(arst_n), .link(link_if.host), .cmd_valid(cmd_valid),
		.cmd_spi(cmd_spi), .cmd_read(cmd_read), .cmd_strap(cmd_strap), .cmd_ptr(cmd_ptr),
		.cmd_data(cmd_data), .busy(busy), .done(done), .rd_data(rd_data), .nack(nack));
	dmcp_link_asserts dmcp_link_asserts_inst (.clk(clk), .arst_n(arst_n), .ctrl_clk(link_if.ctrl_clk),
		.sel_pin(link_if.sel_pin), .data_in(link_if.data_in), .sda(link_if.sda),
		.sda_host_o(link_if.sda_host_o), .sda_host_oe(link_if.sda_host_oe),
		.sda_dev_o(link_if.sda_dev_o), .sda_dev_oe(link_if.sda_dev_oe));
	// clock generator, master clock never stops during i2c
	always #50 clk = ~clk;
	// compare and count
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// expected register image from the model
	function logic [39:0] img();
		logic [39:0] v;
		v = '0;
		for (int i = 0; i < NUM_REGS; i++) v[8*i+:8] = mdl[i][7:0];
		return v;
	endfunction
	// one host command, waits for done under a bound
	task cmd(input logic spi, input logic rd, input logic strap, input logic [7:0] p, input logic [7:0] d);
		int i;
		@(posedge clk);
		#1;
		cmd_spi = spi;
		cmd_read = rd;
		cmd_strap = strap;
		cmd_ptr = p;
		cmd_data = d;
		cmd_valid = 1'b1;
		@(posedge clk);
		#1;
		cmd_valid = 1'b0;
		for (i = 0; i < 3000 && done !== 1'b1; i++) begin
			@(posedge clk);
			#1;
		end
		if (i == 3000) failures++;
		// register image lands one cycle after the store
		repeat (4) @(posedge clk);
		#1;
		chk(busy, 1'b0);
	endtask
	// write one register, set the model pointer and advance it when p[7] is set
	task wr(input logic spi, input logic [7:0] p, input logic [7:0] d);
		cmd(spi, 1'b0, 1'b1, p, d);
		if (!spi) chk(nack, 1'b0);
		mptr = p;
		if (p[2:0] < NUM_REGS) mdl[p[2:0]] = d;
		if (p[7]) mptr = {p[7:3], p[2:0] + 3'd1};
		chk(regs_out, img());
	endtask
	// read one byte at the current pointer
	task rd_chk();
		logic [7:0] e;
		e = (mptr[2:0] < NUM_REGS) ? mdl[mptr[2:0]][7:0] : 8'h00;
		cmd(1'b0, 1'b1, 1'b1, 8'h00, 8'h00);
		chk(nack, 1'b0);
		chk(rd_data, e);
		if (mptr[7]) mptr = {mptr[7:3], mptr[2:0] + 3'd1};
	endtask
	// verdict and end of run
	task end_sim();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// watchdog, several times the expected run length
	initial begin
		#5_000_000;
		failures++;
		end_sim();
	end
	// main sequence
	initial begin
		for (int i = 0; i < NUM_REGS; i++) mdl[i] = 0;
		repeat (12) @(posedge clk);
		#1;
		arst_n = 1'b1;
		repeat (2) @(posedge clk);
		#1;
		chk(regs_out, 40'h0);
		chk(spi_mode, 1'b0);
		rd_chk();
		// every select value 0 to 7, unused ones must be ignored
		for (int p = 0; p < 8; p++) wr(1'b0, p[7:0], 8'($random(seed)));
		rd_chk();
		wr(1'b0, 8'h02, 8'($random(seed)));
		rd_chk();
		rd_chk();
		// auto-increment across the unused slots and the wrap
		wr(1'b0, 8'h83, 8'($random(seed)));
		repeat (5) rd_chk();
		wr(1'b0, 8'h84, 8'($random(seed)));
		rd_chk();
		// wrong address-select bit must be left unanswered
		cmd(1'b0, 1'b0, 1'b0, 8'h01, 8'($random(seed)));
		chk(nack, 1'b1);
		chk(regs_out, img());
		cmd(1'b0, 1'b1, 1'b0, 8'h00, 8'h00);
		chk(nack, 1'b1);
		rd_chk();
		// select falls: spi writes from here on
		for (int p = 0; p < 6; p++) wr(1'b1, {p[0], 4'h0, p[2:0]}, 8'($random(seed)));
		chk(spi_mode, 1'b1);
		end_sim();
	end
endmodule // test_dual_mode_control_port
